// *** core/cmx_host_ctrl.sv ***
// Host controller end: frames the configuration word onto the link.
// Assumes the lower 46 bits come ready-made from the user side.
`include "cmx_regs.svh"

module cmx_host_ctrl (
    input wire logic clk,
    input wire logic reset_n,
    cmx_link_if.host link,
    input wire logic start,
    input wire logic systemSafe,
    input wire logic [`CMX_LOWER_W-1:0] lowerFields,
    input wire logic [3:0] mixSel,
    input wire logic bridgeRequest,
    input wire logic [4:0] highCompReq,
    input wire logic [4:0] lowCompReq,
    input wire logic autoPowerSaveReq,
    input wire cmx_pkg::cmx_pwm_t pwmModeReq,
    input wire logic useRecommended,
    output logic busy
);
    import cmx_pkg::*;

    cmx_hstate_t state_q, state_d;
    logic [`CMX_WORD_BITS-1:0] word_q, word_d;
    logic [`CMX_CNT_W-1:0] count_q, count_d;
    logic sel_q, sel_d, strobe_q, strobe_d, bit_q, bit_d;
    // Busy is registered so that the port comes straight from a flop.
    logic busy_q, busy_d;
    logic [4:0] hClamp, lClamp;
    cmx_pwm_t pwmPick;
    logic [`CMX_WORD_BITS-1:0] built;

    // ************************************************************
    // Word assembly
    // ************************************************************
    always_comb begin
        hClamp = highCompReq;
        if (hClamp < `CMX_HCOMP_MIN) begin
            hClamp = `CMX_HCOMP_MIN;
        end else if (hClamp > `CMX_HCOMP_MAX) begin
            hClamp = `CMX_HCOMP_MAX;
        end
        lClamp = (lowCompReq > `CMX_LCOMP_MAX) ? `CMX_LCOMP_MAX :
            lowCompReq;
        pwmPick = useRecommended ? PWM_H_1M : pwmModeReq;
        built = {pwmPick[0], pwmPick[1], autoPowerSaveReq, lClamp, hClamp,
            bridgeRequest && systemSafe, mixSel, lowerFields};
    end

    // ************************************************************
    // Frame sequencer
    // ************************************************************
    always_comb begin
        state_d = state_q;
        word_d = word_q;
        count_d = count_q;
        sel_d = sel_q;
        strobe_d = 1'b0;
        bit_d = bit_q;
        case (state_q)
            HST_IDLE: begin
                sel_d = 1'b0;
                if (start) begin
                    word_d = built;
                    count_d = '0;
                    sel_d = 1'b1;
                    state_d = HST_SHIFT;
                end
            end
            HST_SHIFT: begin
                strobe_d = 1'b1;
                bit_d = word_q[`CMX_WORD_BITS-1];
                word_d = {word_q[`CMX_WORD_BITS-2:0], 1'b0};
                count_d = count_q + `CMX_CNT_W'(1);
                if (count_q == `CMX_CNT_W'(`CMX_WORD_BITS - 1)) begin
                    state_d = HST_END;
                end
            end
            HST_END: begin
                sel_d = 1'b0;
                state_d = HST_IDLE;
            end
            default: begin
                state_d = HST_IDLE;
            end
        endcase
        busy_d = (state_d != HST_IDLE) || sel_d;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= HST_IDLE;
            word_q <= '0;
            count_q <= '0;
            sel_q <= 1'b0;
            strobe_q <= 1'b0;
            bit_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            word_q <= word_d;
            count_q <= count_d;
            sel_q <= sel_d;
            strobe_q <= strobe_d;
            bit_q <= bit_d;
            busy_q <= busy_d;
        end
    end

    assign link.frameSel = sel_q;
    assign link.shiftStrobe = strobe_q;
    assign link.shiftBit = bit_q;
    assign busy = busy_q;
endmodule : cmx_host_ctrl

// *** core/cmx_link_if.sv ***
// Configuration link between the host controller and the amplifier.
// Both ends run on the same clock; no synchroniser is needed.
interface cmx_link_if;
    logic frameSel;
    logic shiftStrobe;
    logic shiftBit;

    modport host (output frameSel, output shiftStrobe, output shiftBit);
    modport device (input frameSel, input shiftStrobe, input shiftBit);
endinterface : cmx_link_if

// *** core/cmx_mix_device.sv ***
// Amplifier end: receives the configuration word and mixes the channels.
// Assumes the host frames whole 64-bit words on the link, bit 63 first.
`include "cmx_regs.svh"

// How it works
// - Four mix bits at 46..49 steer channels.
// - Upper mix bits choose left output source.
// - Lower mix bits choose right output source.
// - Mix field resets to 1001, straight through.
// - Bit 50 gates the output bridge drive.
// - Bridge drive is off after reset.
// - Host enables bridge only once safe.
// - Low compensation defaults 00000, host keeps <=01000.
// - High compensation defaults 10000, host keeps >=01000.
// - Bit 61 enables power save and silence.
// - Bit 62 speed, bit 63 modulation method.
// - Pair picks R500k, H1M, R1M, H2M.
// - Host first configures H modulation 1MHz.
// - High compensation occupies bits 51..55.
// - Low compensation occupies bits 56..60.
module cmx_mix_device #(
    parameter int SAMPLE_W = 24
) (
    input wire logic clk,
    input wire logic reset_n,
    cmx_link_if.device link,
    input wire logic signed [SAMPLE_W-1:0] leftIn,
    input wire logic signed [SAMPLE_W-1:0] rightIn,
    input wire logic sampleValid,
    output logic signed [SAMPLE_W-1:0] leftOut,
    output logic signed [SAMPLE_W-1:0] rightOut,
    output logic outValid,
    output logic bridgeEnable,
    output logic [4:0] highComp,
    output logic [4:0] lowComp,
    output logic autoPowerSave,
    output logic silenceActive,
    output cmx_pkg::cmx_pwm_t pwmMode,
    output logic configDone
);
    import cmx_pkg::*;

    // Below two bits the half sum would have no room for a sign.
    if (SAMPLE_W < 2) begin : gBadSample
        $error("SAMPLE_W must be at least 2");
    end
    // The frame counter has to reach a whole word without wrapping.
    if ((1 << `CMX_CNT_W) <= `CMX_WORD_BITS) begin : gBadCount
        $error("CMX_CNT_W too narrow for the word length");
    end

    // ************************************************************
    // Configuration receiver
    // ************************************************************
    logic [`CMX_WORD_BITS-1:0] shift_q, shift_d;
    logic [`CMX_CNT_W-1:0] count_q, count_d;
    logic frameSel_q;
    logic commit;
    logic [3:0] mix_q, mix_d;
    logic bridge_q, bridge_d;
    logic [4:0] hComp_q, hComp_d;
    logic [4:0] lComp_q, lComp_d;
    logic aps_q, aps_d;
    cmx_pwm_t pwm_q, pwm_d;
    logic done_q, done_d;

    // A frame that ends short or long is dropped whole, so a glitch on
    // the link can never leave half-updated fields behind.
    assign commit = frameSel_q && !link.frameSel &&
        (count_q == `CMX_CNT_W'(`CMX_WORD_BITS));

    always_comb begin
        shift_d = shift_q;
        count_d = count_q;
        if (!link.frameSel) begin
            count_d = '0;
        end else if (link.shiftStrobe) begin
            shift_d = {shift_q[`CMX_WORD_BITS-2:0], link.shiftBit};
            // The count saturates so that an overlong frame can never
            // wrap back round to a valid length.
            if (count_q != {`CMX_CNT_W{1'b1}}) begin
                count_d = count_q + `CMX_CNT_W'(1);
            end
        end
    end

    always_comb begin
        mix_d = mix_q;
        bridge_d = bridge_q;
        hComp_d = hComp_q;
        lComp_d = lComp_q;
        aps_d = aps_q;
        pwm_d = pwm_q;
        done_d = commit;
        if (commit) begin
            mix_d = shift_q[`CMX_MIX_HI:`CMX_MIX_LO];
            bridge_d = shift_q[`CMX_BRIDGE_BIT];
            hComp_d = shift_q[`CMX_HCOMP_HI:`CMX_HCOMP_LO];
            lComp_d = shift_q[`CMX_LCOMP_HI:`CMX_LCOMP_LO];
            aps_d = shift_q[`CMX_APS_BIT];
            pwm_d = cmx_pwm_t'({shift_q[`CMX_SPEED_BIT],
                shift_q[`CMX_MOD_BIT]});
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shift_q <= '0;
            count_q <= '0;
            frameSel_q <= 1'b0;
            mix_q <= `CMX_MIX_RST;
            bridge_q <= `CMX_BRIDGE_RST;
            hComp_q <= `CMX_HCOMP_RST;
            lComp_q <= `CMX_LCOMP_RST;
            aps_q <= `CMX_APS_RST;
            pwm_q <= PWM_R_500K;
            done_q <= 1'b0;
        end else begin
            shift_q <= shift_d;
            count_q <= count_d;
            frameSel_q <= link.frameSel;
            mix_q <= mix_d;
            bridge_q <= bridge_d;
            hComp_q <= hComp_d;
            lComp_q <= lComp_d;
            aps_q <= aps_d;
            pwm_q <= pwm_d;
            done_q <= done_d;
        end
    end

    // ************************************************************
    // Channel mixer
    // ************************************************************
    logic signed [SAMPLE_W:0] sumWide;
    logic signed [SAMPLE_W-1:0] halfSum;
    logic signed [SAMPLE_W-1:0] leftOut_d, rightOut_d;
    logic signed [SAMPLE_W-1:0] leftOut_q, rightOut_q;
    logic valid_d, valid_q;
    logic silence_d, silence_q;

    // One extra bit keeps the sum from wrapping before the halving.
    assign sumWide = {leftIn[SAMPLE_W-1], leftIn} +
        {rightIn[SAMPLE_W-1], rightIn};
    assign halfSum = SAMPLE_W'(sumWide >>> 1);

    function automatic logic signed [SAMPLE_W-1:0] pick(
        input cmx_src_t sel,
        input logic signed [SAMPLE_W-1:0] l,
        input logic signed [SAMPLE_W-1:0] r,
        input logic signed [SAMPLE_W-1:0] h
    );
        case (sel)
            MIX_RIGHT: pick = r;
            MIX_LEFT: pick = l;
            MIX_HALFSUM: pick = h;
            default: pick = '0;
        endcase
    endfunction : pick

    // The mix in force at the sampling edge is used; a word that lands
    // in the same cycle as a sample only steers the following sample.
    always_comb begin
        leftOut_d = leftOut_q;
        rightOut_d = rightOut_q;
        valid_d = sampleValid;
        if (sampleValid) begin
            leftOut_d = pick(cmx_src_t'(mix_q[3:2]), leftIn, rightIn,
                halfSum);
            rightOut_d = pick(cmx_src_t'(mix_q[1:0]), leftIn, rightIn,
                halfSum);
        end
        // Silence is only reported while power save is on, so the output
        // stage never idles unless the host asked for it.
        silence_d = aps_q && (leftOut_d == '0) &&
            (rightOut_d == '0);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            leftOut_q <= '0;
            rightOut_q <= '0;
            valid_q <= 1'b0;
            silence_q <= 1'b0;
        end else begin
            leftOut_q <= leftOut_d;
            rightOut_q <= rightOut_d;
            valid_q <= valid_d;
            silence_q <= silence_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign leftOut = leftOut_q;
    assign rightOut = rightOut_q;
    assign outValid = valid_q;
    assign bridgeEnable = bridge_q;
    assign highComp = hComp_q;
    assign lowComp = lComp_q;
    assign autoPowerSave = aps_q;
    assign silenceActive = silence_q;
    assign pwmMode = pwm_q;
    assign configDone = done_q;
endmodule : cmx_mix_device

// *** core/cmx_pkg.sv ***
// Types shared by both ends of the configuration link and the mixer.
// Assumes cmx_regs.svh supplies the bit positions.
package cmx_pkg;
    // Source chosen for one output channel.
    typedef enum logic [1:0] {
        MIX_MUTE = 2'b00,
        MIX_RIGHT = 2'b01,
        MIX_LEFT = 2'b10,
        MIX_HALFSUM = 2'b11
    } cmx_src_t;

    // Speed and modulation pair, speed in the upper bit.
    typedef enum logic [1:0] {
        PWM_R_500K = 2'b00,
        PWM_H_1M = 2'b01,
        PWM_R_1M = 2'b10,
        PWM_H_2M = 2'b11
    } cmx_pwm_t;

    typedef enum logic [1:0] {
        HST_IDLE = 2'b00,
        HST_SHIFT = 2'b01,
        HST_END = 2'b10
    } cmx_hstate_t;
endpackage : cmx_pkg

// *** core/cmx_regs.svh ***
// Bit positions and reset values of the upper configuration word fields.
// Assumes a 64-bit configuration word, bit 63 sent first on the link.
`ifndef CMX_REGS_SVH
`define CMX_REGS_SVH

`define CMX_WORD_BITS 64
`define CMX_CNT_W 7
`define CMX_MIX_LO 46
`define CMX_MIX_HI 49
`define CMX_BRIDGE_BIT 50
`define CMX_HCOMP_LO 51
`define CMX_HCOMP_HI 55
`define CMX_LCOMP_LO 56
`define CMX_LCOMP_HI 60
`define CMX_APS_BIT 61
`define CMX_SPEED_BIT 62
`define CMX_MOD_BIT 63
`define CMX_MIX_RST 4'h9
`define CMX_BRIDGE_RST 1'b0
`define CMX_APS_RST 1'b0
`define CMX_HCOMP_RST 5'h10
`define CMX_LCOMP_RST 5'h00
`define CMX_HCOMP_MIN 5'h08
`define CMX_HCOMP_MAX 5'h10
`define CMX_LCOMP_MAX 5'h08
`define CMX_LOWER_W 46
`define CMX_LOWER_RST 46'h0000_0000_0000

`endif

// *** test/cmx_link_chk.sv ***
// Checker for the configuration link and the fields that it loads.
// Assumes it sits beside the link joining the host and amplifier ends.
module cmx_link_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic frameSel,
    input wire logic shiftStrobe,
    input wire logic shiftBit,
    input wire logic configDone,
    input wire logic bridgeEnable,
    input wire logic [4:0] highComp,
    input wire logic [4:0] lowComp,
    input wire logic autoPowerSave,
    input wire cmx_pkg::cmx_pwm_t pwmMode
);
    timeunit 1ns;
    timeprecision 1ns;
    import cmx_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // ****************************************
    // Strobe count of the frame in progress
    // ****************************************
    logic [6:0] bitCnt_q;
    logic [6:0] bitCnt_d;
    always_comb begin
        bitCnt_d = frameSel ? bitCnt_q + 7'(shiftStrobe) : 7'h00;
    end
    always_ff @(posedge clk) begin
        bitCnt_q <= reset_n ? bitCnt_d : 7'h00;
    end

    // ****************************************
    // Link and field properties
    // ****************************************
    a_strobe_in_frame: assert property (
        shiftStrobe |-> frameSel)
        else $error("strobe outside a frame");
    a_frame_count: assert property (
        $fell(frameSel) |-> bitCnt_q == 7'd64)
        else $error("frame did not carry 64 bits");
    a_frame_gap: assert property (
        $fell(frameSel) |=> !frameSel)
        else $error("frames too close together");
    a_done_after_frame: assert property (
        configDone |-> !$past(frameSel) && $past(frameSel, 2))
        else $error("load pulse not tied to frame end");
    a_done_one_cycle: assert property (
        configDone |=> !configDone [*8])
        else $error("load pulse too long or too close");
    // The past-reset term keeps a mid-run reset from looking like a change.
    a_fields_hold: assert property (
        !configDone && $past(reset_n) |-> $stable({bridgeEnable,
        highComp, lowComp, autoPowerSave, pwmMode}))
        else $error("fields changed without a load");
    a_reset_values: assert property (
        !$past(reset_n) |-> !bridgeEnable && highComp == 5'h10 &&
        lowComp == 5'h00 && !autoPowerSave && pwmMode == PWM_R_500K)
        else $error("fields wrong after reset");
    a_comp_range: assert property (
        configDone |-> highComp >= 5'h08 && highComp <= 5'h10 &&
        lowComp <= 5'h08)
        else $error("compensation out of range");
endmodule : cmx_link_chk

// *** test/tb.sv ***
// Testbench joining the host end to the amplifier end over the link.
// Assumes a 100 MHz clock and a synchronous active-low reset.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cmx_pkg::*;
    localparam logic [23:0] LV = 24'h80_0001;
    localparam logic [23:0] RV = 24'h80_0003;
    localparam logic [45:0] LOWER = 46'h2A5A_C3C3_0F0F;
    logic clk, reset_n, start, systemSafe, bridgeRequest, useRecommended;
    logic autoPowerSaveReq, sampleValid, busy, outValid, configDone;
    logic bridgeEnable, autoPowerSave, silenceActive, done2, bridge2;
    logic [3:0] mixSel;
    logic [4:0] highCompReq, lowCompReq, highComp, lowComp;
    logic [23:0] leftIn, rightIn, leftOut, rightOut;
    logic [63:0] cap;
    logic [6:0] nBits;
    cmx_pwm_t pwmModeReq, pwmMode;
    int miscompares, check_count, cycles;
    cmx_link_if link();
    cmx_link_if bad();

    cmx_host_ctrl u_cmx_host_ctrl (.clk(clk), .reset_n(reset_n),
        .link(link), .start(start), .systemSafe(systemSafe),
        .lowerFields(LOWER), .mixSel(mixSel),
        .bridgeRequest(bridgeRequest), .highCompReq(highCompReq),
        .lowCompReq(lowCompReq), .autoPowerSaveReq(autoPowerSaveReq),
        .pwmModeReq(pwmModeReq), .useRecommended(useRecommended),
        .busy(busy));
    cmx_mix_device u_cmx_mix_device (.clk(clk), .reset_n(reset_n),
        .link(link), .leftIn(leftIn), .rightIn(rightIn),
        .sampleValid(sampleValid), .leftOut(leftOut),
        .rightOut(rightOut), .outValid(outValid),
        .bridgeEnable(bridgeEnable), .highComp(highComp),
        .lowComp(lowComp), .autoPowerSave(autoPowerSave),
        .silenceActive(silenceActive), .pwmMode(pwmMode),
        .configDone(configDone));
    // This copy only ever sees frames that break the framing on purpose.
    cmx_mix_device u_cmx_mix_device_2 (.clk(clk), .reset_n(reset_n),
        .link(bad), .leftIn(leftIn), .rightIn(rightIn),
        .sampleValid(sampleValid), .leftOut(), .rightOut(),
        .outValid(), .bridgeEnable(bridge2), .highComp(),
        .lowComp(), .autoPowerSave(), .silenceActive(),
        .pwmMode(), .configDone(done2));
    cmx_link_chk u_cmx_link_chk (.clk(clk), .reset_n(reset_n),
        .frameSel(link.frameSel), .shiftStrobe(link.shiftStrobe),
        .shiftBit(link.shiftBit), .configDone(configDone),
        .bridgeEnable(bridgeEnable), .highComp(highComp),
        .lowComp(lowComp), .autoPowerSave(autoPowerSave),
        .pwmMode(pwmMode));

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (start) nBits <= 0;
        else if (link.frameSel && link.shiftStrobe) begin
            cap <= {cap[62:0], link.shiftBit};
            nBits <= nBits + 7'd1;
        end
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            give_verdict();
        end
    end

    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic chk(input string n, input logic [63:0] e, s);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    function automatic logic [63:0] word(input logic [3:0] m,
        input logic b, input logic [4:0] h, l, input logic a,
        input logic [1:0] p);
        return {p[0], p[1], a, l, h, b, m, LOWER};
    endfunction : word
    function automatic logic [23:0] pick(input logic [1:0] s,
        input logic [23:0] l, r);
        logic [24:0] t;
        t = {l[23], l} + {r[23], r};
        case (s)
            2'b00: return 24'h00_0000;
            2'b01: return r;
            2'b10: return l;
            default: return t[24:1];
        endcase
    endfunction : pick
    task automatic send(input logic [63:0] e);
        @(posedge clk);
        start <= 1;
        @(posedge clk);
        start <= 0;
        @(posedge clk);
        chk("busy", 1, busy);
        for (int i = 0; i < 100 && configDone !== 1; i++) @(posedge clk);
        chk("done", 1, configDone);
        chk("busy", 0, busy);
        chk("word", e, cap);
        chk("bits", 64, nBits);
    endtask : send
    task automatic smp(input logic [23:0] el, er);
        @(posedge clk);
        leftIn <= LV;
        rightIn <= RV;
        sampleValid <= 1;
        @(posedge clk);
        sampleValid <= 0;
        @(posedge clk);
        chk("valid", 1, outValid);
        chk("left", el, leftOut);
        chk("right", er, rightOut);
    endtask : smp

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset;
        reset_n <= 0;
        repeat (3) @(posedge clk);
        reset_n <= 1;
        chk("bridge", 0, bridgeEnable);
        chk("high", 5'h10, highComp);
        chk("low", 5'h00, lowComp);
        chk("mode", 0, pwmMode);
        chk("aps", 0, autoPowerSave);
        chk("busy", 0, busy);
        smp(LV, RV);
        $display("test reset finished");
    endtask : test_reset
    task automatic test_mix;
        for (int c = 0; c < 16; c++) begin
            mixSel <= 4'(c);
            bridgeRequest <= 1;
            systemSafe <= 1;
            send(word(4'(c), 1, 5'h10, 5'h00, 0, 2'b00));
            smp(pick(c[3:2], LV, RV), pick(c[1:0], LV, RV));
        end
        chk("bridge", 1, bridgeEnable);
        $display("test mix finished");
    endtask : test_mix
    task automatic test_cfg;
        systemSafe <= 0;
        highCompReq <= 5'h1F;
        lowCompReq <= 5'h1F;
        mixSel <= 4'h9;
        send(word(4'h9, 0, 5'h10, 5'h08, 0, 2'b00));
        chk("bridge", 0, bridgeEnable);
        chk("low", 5'h08, lowComp);
        highCompReq <= 5'h00;
        lowCompReq <= 5'h00;
        send(word(4'h9, 0, 5'h08, 5'h00, 0, 2'b00));
        chk("high", 5'h08, highComp);
        for (int m = 0; m < 4; m++) begin
            pwmModeReq <= cmx_pwm_t'(m);
            autoPowerSaveReq <= m[0];
            send(word(4'h9, 0, 5'h08, 5'h00, m[0], 2'(m)));
            chk("mode", m, pwmMode);
            chk("aps", m[0], autoPowerSave);
        end
        useRecommended <= 1;
        send(word(4'h9, 0, 5'h08, 5'h00, 1, 2'b01));
        chk("mode", 1, pwmMode);
        useRecommended <= 0;
        $display("test config finished");
    endtask : test_cfg
    task automatic test_silence;
        for (int a = 1; a >= 0; a--) begin
            mixSel <= 4'h0;
            autoPowerSaveReq <= a[0];
            send(word(4'h0, 0, 5'h08, 5'h00, a[0], 2'b11));
            smp(24'h00_0000, 24'h00_0000);
            chk("silence", a[0], silenceActive);
        end
        $display("test silence finished");
    endtask : test_silence
    task automatic test_short;
        logic seen;
        seen = 0;
        @(posedge clk);
        bad.frameSel <= 1;
        for (int i = 0; i < 63; i++) begin
            @(posedge clk);
            bad.shiftStrobe <= 1;
            bad.shiftBit <= 1;
        end
        @(posedge clk);
        bad.frameSel <= 0;
        bad.shiftStrobe <= 0;
        bad.shiftBit <= 0;
        repeat (6) begin
            @(posedge clk);
            if (done2 === 1) seen = 1;
        end
        chk("short load", 0, seen);
        chk("short bridge", 0, bridge2);
        $display("test short frame finished");
    endtask : test_short

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    initial begin
        {reset_n, start, systemSafe, bridgeRequest, useRecommended} = 0;
        {autoPowerSaveReq, sampleValid, leftIn, rightIn} = 0;
        {bad.frameSel, bad.shiftStrobe, bad.shiftBit, cycles} = 0;
        {miscompares, check_count, nBits, cap} = 0;
        mixSel = 4'h9;
        highCompReq = 5'h10;
        lowCompReq = 5'h00;
        pwmModeReq = PWM_R_500K;
        test_reset();
        test_mix();
        test_reset();
        test_cfg();
        test_silence();
        test_short();
        give_verdict();
    end
endmodule : tb
